// ---- common/daacsr_consts.svh ----
// offsets, field positions, reset values and codes of the line interface register bank
`ifndef DAACSR_CONSTS_SVH
`define DAACSR_CONSTS_SVH

// bus geometry
`define DAACSR_ADDR_W 8
`define DAACSR_IDX_W 6

// register indices, byte address is four times the index
`define DAACSR_IDX_CALL_PROGRESS_OUTPUT_CTRL 6'h06
`define DAACSR_IDX_RSVD_SEVEN 6'h07
`define DAACSR_IDX_RSVD_EIGHT 6'h08
`define DAACSR_IDX_SAMPLE_RATE 6'h09
`define DAACSR_IDX_RSVD_TEN 6'h0A
`define DAACSR_IDX_SYS_REV 6'h0B
`define DAACSR_IDX_LINK_STATUS 6'h0C
`define DAACSR_IDX_LINE_REV 6'h0D

// reset values
`define DAACSR_CALL_PROGRESS_OUTPUT_CTRL_RST 8'h70
`define DAACSR_SAMPLE_RATE_RST 3'h0
`define DAACSR_LEGACY_RST 1'h0

// writable bits of the level and power register
`define DAACSR_CALL_PROGRESS_OUTPUT_CTRL_MASK 8'h7B

// field positions
`define DAACSR_TXLVL_HI 6
`define DAACSR_TXLVL_LO 1
`define DAACSR_RXLVL_HI 5
`define DAACSR_RXLVL_LO 0
`define DAACSR_LINE_PD_BIT 4
`define DAACSR_SYS_PD_BIT 3
`define DAACSR_LINKERR_BIT 7
`define DAACSR_LRXG_BIT 1
`define DAACSR_LTXA_BIT 0

// level codes and their attenuation in dB
`define DAACSR_LVL_MUTE 2'h2
`define DAACSR_TX_ATT_00 6'h1A
`define DAACSR_TX_ATT_01 6'h14
`define DAACSR_TX_ATT_11 6'h20
`define DAACSR_RX_ATT_00 6'h06
`define DAACSR_RX_ATT_01 6'h00
`define DAACSR_RX_ATT_11 6'h0C

// sample rates in Hz
`define DAACSR_RATE_0 14'h1C20
`define DAACSR_RATE_1 14'h1F40
`define DAACSR_RATE_2 14'h2025
`define DAACSR_RATE_3 14'h20D0
`define DAACSR_RATE_4 14'h2328
`define DAACSR_RATE_5 14'h2580
`define DAACSR_RATE_6 14'h282E
`define DAACSR_RATE_RSVD 3'h7

// loop current exception codes
`define DAACSR_CODE_HIGH_EXC 5'h1E
`define DAACSR_LEVEL_HIGH_EXC 4'hE
`define DAACSR_CODE_LOW_EXC 5'h01
`define DAACSR_LEVEL_LOW_EXC 4'h1

// bus responses
`define DAACSR_RESP_OKAY 2'h0
`define DAACSR_RESP_SLVERR 2'h2

`endif

// ---- common/daacsr_pkg.sv ----
// types of the line interface register bank
`include "daacsr_consts.svh"

package daacsr_pkg;

  // state of the loop current decoder
  typedef struct packed {
    logic [3:0] level;
  } daacsr_loop_state_type;

  // settings decoded for the call-progress output
  typedef struct packed {
    logic tx_mute;
    logic rx_mute;
    logic [5:0] tx_atten_db;
    logic [5:0] rx_atten_db;
  } daacsr_call_progress_output_type;

  // whole state of the register bank and its bus slave
  typedef struct packed {
    logic [7:0] call_progress_output_ctrl;
    logic [2:0] sample_rate_select;
    logic link_error;
    logic legacy_rx_gain;
    logic legacy_tx_atten;
    logic aw_have;
    logic [`DAACSR_IDX_W-1:0] aw_idx;
    logic w_have;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    daacsr_call_progress_output_type call_progress_output;
    logic [13:0] rate_hz;
    logic rate_valid;
  } daacsr_state_type;

endpackage : daacsr_pkg

// ---- verilog/daacsr_lcs_decode.sv ----
// loop current decoder from the line voltage/current code
`timescale 1ns/1ps

module daacsr_loop_decode
  import daacsr_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic off_hook_i,
  input wire logic [4:0] line_volt_current_code_i,
  output logic [3:0] loop_current_level_o
);

  daacsr_loop_state_type state_reg;
  daacsr_loop_state_type state_next;

  // next decoded level
  always_comb begin
    state_next = state_reg;
    state_next.level = line_volt_current_code_i[4:1];
    if (off_hook_i) begin
      if (line_volt_current_code_i == `DAACSR_CODE_HIGH_EXC) begin
        state_next.level = `DAACSR_LEVEL_HIGH_EXC;
      end else if (line_volt_current_code_i == `DAACSR_CODE_LOW_EXC) begin
        state_next.level = `DAACSR_LEVEL_LOW_EXC;
      end
    end
  end

  // level register
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign loop_current_level_o = state_reg.level;

endmodule : daacsr_loop_decode

// ---- verilog/daacsr_top.sv ----
// control and status register bank of the line interface, AXI4-Lite slave
//
// Summary of operation
// - tx level field bits 6,1 sets output attenuation
// - rx level field bits 5,0 sets output attenuation
// - bit 4 powers down line side part
// - bit 3 powerdown held until module reset
// - level register resets to 0111_0000
// - bits 2:0 select sample rate, 111 reserved
// - revision code bits 3:0, upper bits zero
// - link error sticky until software writes zero
// - frame lock flag shows live link lock
// - off-hook loop current with two exception codes
// - on-hook loop current is plain code slice
// - legacy rx gain bit adds receive gain
// - legacy tx attenuation bit attenuates transmit
`timescale 1ns/1ps

module daacsr_top
  import daacsr_pkg::*;
#(
  // arbitrary neutral revision value
  parameter logic [3:0] SYS_REV_CODE = 4'h1
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // write address channel
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [`DAACSR_ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic [2:0] s_axi_awprot_i,
  // write data channel
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  // write response channel
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  // read address channel
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [`DAACSR_ADDR_W-1:0] s_axi_araddr_i,
  input wire logic [2:0] s_axi_arprot_i,
  // read data channel
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  // live sources from the line side
  input wire logic off_hook_i,
  input wire logic [4:0] line_volt_current_code_i,
  input wire logic link_error_event_i,
  input wire logic frame_lock_i,
  input wire logic line_side_intl_flag_i,
  input wire logic [3:0] line_side_rev_code_i,
  input wire logic sys_module_reset_i,
  // decoded controls
  output logic [1:0] call_progress_output_tx_level_o,
  output logic [1:0] call_progress_output_rx_level_o,
  output logic call_progress_output_tx_mute_o,
  output logic call_progress_output_rx_mute_o,
  output logic [5:0] call_progress_output_tx_atten_db_o,
  output logic [5:0] call_progress_output_rx_atten_db_o,
  output logic line_side_powerdown_o,
  output logic system_side_powerdown_o,
  output logic [2:0] sample_rate_select_o,
  output logic [13:0] sample_rate_hz_o,
  output logic sample_rate_valid_o,
  output logic legacy_rx_gain_o,
  output logic legacy_tx_atten_o,
  output logic [3:0] loop_current_level_o
);

  daacsr_state_type state_reg;
  daacsr_state_type state_next;
  logic [3:0] loop_level;

  // sample rate code to Hz, reserved code gives zero
  function automatic logic [13:0] rate_of(input logic [2:0] code);
    logic [13:0] hz;
    hz = 14'h0000;
    case (code)
      3'h0: hz = `DAACSR_RATE_0;
      3'h1: hz = `DAACSR_RATE_1;
      3'h2: hz = `DAACSR_RATE_2;
      3'h3: hz = `DAACSR_RATE_3;
      3'h4: hz = `DAACSR_RATE_4;
      3'h5: hz = `DAACSR_RATE_5;
      3'h6: hz = `DAACSR_RATE_6;
      default: hz = 14'h0000;
    endcase
    return hz;
  endfunction : rate_of

  // call-progress level decode
  function automatic daacsr_call_progress_output_type call_progress_output_of(input logic [1:0] tx, input logic [1:0] rx);
    daacsr_call_progress_output_type a;
    a = '0;
    case (tx)
      2'h0: a.tx_atten_db = `DAACSR_TX_ATT_00;
      2'h1: a.tx_atten_db = `DAACSR_TX_ATT_01;
      2'h3: a.tx_atten_db = `DAACSR_TX_ATT_11;
      default: a.tx_atten_db = 6'h00;
    endcase
    a.tx_mute = (tx == `DAACSR_LVL_MUTE);
    case (rx)
      2'h0: a.rx_atten_db = `DAACSR_RX_ATT_00;
      2'h1: a.rx_atten_db = `DAACSR_RX_ATT_01;
      2'h3: a.rx_atten_db = `DAACSR_RX_ATT_11;
      default: a.rx_atten_db = 6'h00;
    endcase
    a.rx_mute = (rx == `DAACSR_LVL_MUTE);
    return a;
  endfunction : call_progress_output_of

  // register index of a byte address
  function automatic logic [`DAACSR_IDX_W-1:0] idx_of(input logic [`DAACSR_ADDR_W-1:0] addr);
    return addr[`DAACSR_ADDR_W-1:2];
  endfunction : idx_of

  // loop current decoder
  daacsr_loop_decode u_daacsr_loop_decode (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .off_hook_i(off_hook_i),
    .line_volt_current_code_i(line_volt_current_code_i),
    .loop_current_level_o(loop_level)
  );

  // combinational handshakes
  assign s_axi_awready_o = !state_reg.aw_have && !state_reg.bvalid;
  assign s_axi_wready_o = !state_reg.w_have && !state_reg.bvalid;
  assign s_axi_arready_o = !state_reg.rvalid;

  // next state of registers and bus slave
  always_comb begin
    logic aw_take;
    logic w_take;
    logic do_write;
    logic [`DAACSR_IDX_W-1:0] widx;
    logic [7:0] wd;
    logic wen;
    logic [`DAACSR_IDX_W-1:0] ridx;
    logic err_clear;
    aw_take = 1'b0;
    w_take = 1'b0;
    do_write = 1'b0;
    widx = '0;
    wd = 8'h00;
    wen = 1'b0;
    ridx = '0;
    err_clear = 1'b0;
    state_next = state_reg;

    // capture write address and data in either order
    aw_take = s_axi_awvalid_i && s_axi_awready_o;
    w_take = s_axi_wvalid_i && s_axi_wready_o;
    if (aw_take) begin
      state_next.aw_have = 1'b1;
      state_next.aw_idx = idx_of(s_axi_awaddr_i);
    end
    if (w_take) begin
      state_next.w_have = 1'b1;
      state_next.wdata = s_axi_wdata_i[7:0];
      state_next.wstrb0 = s_axi_wstrb_i[0];
    end
    widx = state_reg.aw_have ? state_reg.aw_idx : idx_of(s_axi_awaddr_i);
    wd = state_reg.w_have ? state_reg.wdata : s_axi_wdata_i[7:0];
    wen = state_reg.w_have ? state_reg.wstrb0 : s_axi_wstrb_i[0];
    do_write = (state_reg.aw_have || aw_take) && (state_reg.w_have || w_take) && !state_reg.bvalid;

    // perform the write and raise the response
    if (do_write) begin
      state_next.aw_have = 1'b0;
      state_next.w_have = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = `DAACSR_RESP_OKAY;
      case (widx)
        `DAACSR_IDX_CALL_PROGRESS_OUTPUT_CTRL: begin
          if (wen) begin
            // reserved bits 7 and 2 stay zero
            state_next.call_progress_output_ctrl = wd & `DAACSR_CALL_PROGRESS_OUTPUT_CTRL_MASK;
            // system side powerdown not cleared by a write
            state_next.call_progress_output_ctrl[`DAACSR_SYS_PD_BIT] = wd[`DAACSR_SYS_PD_BIT] | state_reg.call_progress_output_ctrl[`DAACSR_SYS_PD_BIT];
          end
        end
        `DAACSR_IDX_SAMPLE_RATE: begin
          if (wen) begin
            state_next.sample_rate_select = wd[2:0];
          end
        end
        `DAACSR_IDX_LINK_STATUS: begin
          // only the link error bit is writable
          err_clear = wen && !wd[`DAACSR_LINKERR_BIT];
        end
        `DAACSR_IDX_LINE_REV: begin
          if (wen) begin
            state_next.legacy_rx_gain = wd[`DAACSR_LRXG_BIT];
            state_next.legacy_tx_atten = wd[`DAACSR_LTXA_BIT];
          end
        end
        `DAACSR_IDX_RSVD_SEVEN, `DAACSR_IDX_RSVD_EIGHT, `DAACSR_IDX_RSVD_TEN, `DAACSR_IDX_SYS_REV: begin
          state_next.bresp = `DAACSR_RESP_OKAY;
        end
        default: begin
          state_next.bresp = `DAACSR_RESP_SLVERR;
        end
      endcase
    end
    if (state_reg.bvalid && s_axi_bready_i) begin
      state_next.bvalid = 1'b0;
    end

    // only the module reset restores normal operation
    if (sys_module_reset_i) begin
      state_next.call_progress_output_ctrl[`DAACSR_SYS_PD_BIT] = 1'b0;
    end

    // sticky link error, event wins over clear
    state_next.link_error = (state_reg.link_error && !err_clear) || link_error_event_i;

    // read access, data from registers and live sources
    ridx = idx_of(s_axi_araddr_i);
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      state_next.rvalid = 1'b1;
      state_next.rresp = `DAACSR_RESP_OKAY;
      state_next.rdata = 8'h00;
      case (ridx)
        `DAACSR_IDX_CALL_PROGRESS_OUTPUT_CTRL: begin
          state_next.rdata = state_reg.call_progress_output_ctrl & `DAACSR_CALL_PROGRESS_OUTPUT_CTRL_MASK;
        end
        `DAACSR_IDX_SAMPLE_RATE: begin
          state_next.rdata = {5'h00, state_reg.sample_rate_select};
        end
        `DAACSR_IDX_SYS_REV: begin
          state_next.rdata = {4'h0, SYS_REV_CODE};
        end
        `DAACSR_IDX_LINK_STATUS: begin
          // live frame lock beside sticky error
          state_next.rdata = {state_reg.link_error, frame_lock_i, 2'h0, loop_level};
        end
        `DAACSR_IDX_LINE_REV: begin
          // live line side id and revision
          state_next.rdata = {1'b0, line_side_intl_flag_i, line_side_rev_code_i,
                              state_reg.legacy_rx_gain, state_reg.legacy_tx_atten};
        end
        `DAACSR_IDX_RSVD_SEVEN, `DAACSR_IDX_RSVD_EIGHT, `DAACSR_IDX_RSVD_TEN: begin
          state_next.rdata = 8'h00;
        end
        default: begin
          state_next.rresp = `DAACSR_RESP_SLVERR;
        end
      endcase
    end else if (state_reg.rvalid && s_axi_rready_i) begin
      state_next.rvalid = 1'b0;
    end

    // registered decode of the controls
    state_next.call_progress_output = call_progress_output_of({state_next.call_progress_output_ctrl[`DAACSR_TXLVL_HI], state_next.call_progress_output_ctrl[`DAACSR_TXLVL_LO]},
                              {state_next.call_progress_output_ctrl[`DAACSR_RXLVL_HI], state_next.call_progress_output_ctrl[`DAACSR_RXLVL_LO]});
    // rate lookup, reserved code flagged invalid
    state_next.rate_hz = rate_of(state_next.sample_rate_select);
    state_next.rate_valid = (state_next.sample_rate_select != `DAACSR_RATE_RSVD);
  end

  // state register
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      state_reg <= '0;
      state_reg.call_progress_output_ctrl <= `DAACSR_CALL_PROGRESS_OUTPUT_CTRL_RST;
      state_reg.sample_rate_select <= `DAACSR_SAMPLE_RATE_RST;
      state_reg.legacy_rx_gain <= `DAACSR_LEGACY_RST;
      state_reg.legacy_tx_atten <= `DAACSR_LEGACY_RST;
      state_reg.call_progress_output.tx_mute <= 1'b1;
      state_reg.call_progress_output.rx_mute <= 1'b1;
      state_reg.rate_hz <= `DAACSR_RATE_0;
      state_reg.rate_valid <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // bus outputs
  assign s_axi_bvalid_o = state_reg.bvalid;
  assign s_axi_bresp_o = state_reg.bresp;
  assign s_axi_rvalid_o = state_reg.rvalid;
  assign s_axi_rdata_o = {24'h000000, state_reg.rdata};
  assign s_axi_rresp_o = state_reg.rresp;

  // control outputs
  assign call_progress_output_tx_level_o = {state_reg.call_progress_output_ctrl[`DAACSR_TXLVL_HI], state_reg.call_progress_output_ctrl[`DAACSR_TXLVL_LO]};
  assign call_progress_output_rx_level_o = {state_reg.call_progress_output_ctrl[`DAACSR_RXLVL_HI], state_reg.call_progress_output_ctrl[`DAACSR_RXLVL_LO]};
  assign call_progress_output_tx_mute_o = state_reg.call_progress_output.tx_mute;
  assign call_progress_output_rx_mute_o = state_reg.call_progress_output.rx_mute;
  assign call_progress_output_tx_atten_db_o = state_reg.call_progress_output.tx_atten_db;
  assign call_progress_output_rx_atten_db_o = state_reg.call_progress_output.rx_atten_db;
  assign line_side_powerdown_o = state_reg.call_progress_output_ctrl[`DAACSR_LINE_PD_BIT];
  assign system_side_powerdown_o = state_reg.call_progress_output_ctrl[`DAACSR_SYS_PD_BIT];
  assign sample_rate_select_o = state_reg.sample_rate_select;
  assign sample_rate_hz_o = state_reg.rate_hz;
  assign sample_rate_valid_o = state_reg.rate_valid;
  assign legacy_rx_gain_o = state_reg.legacy_rx_gain;
  assign legacy_tx_atten_o = state_reg.legacy_tx_atten;
  assign loop_current_level_o = loop_level;

endmodule : daacsr_top

// ---- verification/daacsr_chk.sv ----
// assertions on the ports of the line interface register bank
`timescale 1ns/1ps

module daacsr_chk (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic sys_module_reset_i,
  input wire logic off_hook_i,
  input wire logic [4:0] line_volt_current_code_i,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_rvalid_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] call_progress_output_tx_level_o,
  input wire logic [1:0] call_progress_output_rx_level_o,
  input wire logic call_progress_output_tx_mute_o,
  input wire logic call_progress_output_rx_mute_o,
  input wire logic [5:0] call_progress_output_tx_atten_db_o,
  input wire logic [5:0] call_progress_output_rx_atten_db_o,
  input wire logic line_side_powerdown_o,
  input wire logic system_side_powerdown_o,
  input wire logic [2:0] sample_rate_select_o,
  input wire logic [13:0] sample_rate_hz_o,
  input wire logic sample_rate_valid_o,
  input wire logic legacy_rx_gain_o,
  input wire logic legacy_tx_atten_o,
  input wire logic [3:0] loop_current_level_o
);
  // attenuation and rate tables per code
  localparam logic [5:0] TXA [4] = '{6'h1A, 6'h14, 6'h00, 6'h20};
  localparam logic [5:0] RXA [4] = '{6'h06, 6'h00, 6'h00, 6'h0C};
  localparam logic [13:0] HZ [8] = '{14'h1C20, 14'h1F40, 14'h2025, 14'h20D0, 14'h2328, 14'h2580, 14'h282E, 14'h0000};

  // loop current from line code, exceptions only off-hook
  function automatic logic [3:0] loop_of(input logic oh, input logic [4:0] c);
    if (oh && c == 5'h1E) return 4'hE;
    if (oh && c == 5'h01) return 4'h1;
    return c[4:1];
  endfunction : loop_of

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);

  property p_tx_lvl;
    call_progress_output_tx_atten_db_o == TXA[call_progress_output_tx_level_o] && call_progress_output_tx_mute_o == (call_progress_output_tx_level_o == 2'h2);
  endproperty
  a_tx_lvl: assert property (p_tx_lvl) else $error("tx level decode wrong");
  property p_rx_lvl;
    call_progress_output_rx_atten_db_o == RXA[call_progress_output_rx_level_o] && call_progress_output_rx_mute_o == (call_progress_output_rx_level_o == 2'h2);
  endproperty
  a_rx_lvl: assert property (p_rx_lvl) else $error("rx level decode wrong");
  property p_rate;
    sample_rate_hz_o == HZ[sample_rate_select_o] && sample_rate_valid_o == (sample_rate_select_o != 3'h7);
  endproperty
  a_rate: assert property (p_rate) else $error("sample rate decode wrong");
  property p_rst;
    disable iff (1'b0) !resetn_i |=> line_side_powerdown_o && !system_side_powerdown_o && call_progress_output_tx_mute_o
      && call_progress_output_rx_mute_o && sample_rate_select_o == 3'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_pd_hold;
    system_side_powerdown_o && !sys_module_reset_i |=> system_side_powerdown_o;
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("system powerdown left early");
  property p_pd_clr;
    sys_module_reset_i |=> !system_side_powerdown_o;
  endproperty
  a_pd_clr: assert property (p_pd_clr) else $error("module reset kept powerdown");
  property p_loop;
    resetn_i |=> loop_current_level_o == loop_of($past(off_hook_i), $past(line_volt_current_code_i));
  endproperty
  a_loop: assert property (p_loop) else $error("loop current decode wrong");
  property p_lpd;
    $changed(line_side_powerdown_o) |-> $rose(s_axi_bvalid_o);
  endproperty
  a_lpd: assert property (p_lpd) else $error("line powerdown moved without write");
  property p_leg;
    $changed({legacy_rx_gain_o, legacy_tx_atten_o}) |-> $rose(s_axi_bvalid_o);
  endproperty
  a_leg: assert property (p_leg) else $error("legacy bits moved without write");
  property p_rdata;
    s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0;
  endproperty
  a_rdata: assert property (p_rdata) else $error("upper read bits not zero");
endmodule : daacsr_chk

// ---- verification/daa_control_status_regs_tb.sv ----
// self-checking bench of the line interface register bank
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; $display("ERROR %0t got %0h exp %0h", $time, a, b); end end

module daa_control_status_regs_tb;
  logic sys_clk_i = 0, resetn_i = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic oh = 0, lev = 0, fl = 0, intl = 0, srst = 0, hung = 0;
  logic [7:0] awa = 0, ara = 0, d;
  logic [31:0] wd = 0, rdata;
  logic [3:0] ws = 0, rev = 0, lvl;
  logic [2:0] prot = 0, rsel, rate;
  logic [4:0] code = 0;
  logic awr, wrd, bv, arr, rv, txm, rxm, lpd, spd, rval, lrxo, ltxo, system_side_powerdown, lerr, lrx, ltx;
  logic [1:0] bresp, rresp, txl, rxl;
  logic [5:0] txa, rxa;
  logic [13:0] rhz;
  logic [7:0] ctl;
  int num_errors = 0, n_tests = 0, k, j;
  int txt[4] = '{26, 20, 0, 32};
  int rxt[4] = '{6, 0, 0, 12};
  int hzt[8] = '{7200, 8000, 8229, 8400, 9000, 9600, 10286, 0};

  // 200 MHz clock
  always #2.5 sys_clk_i = ~sys_clk_i;

  // revision value is arbitrary
  daacsr_top #(.SYS_REV_CODE(4'h5)) u_daacsr_top (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa), .s_axi_awprot_i(prot),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(bre), .s_axi_bresp_o(bresp),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_araddr_i(ara), .s_axi_arprot_i(prot),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rre), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .off_hook_i(oh), .line_volt_current_code_i(code), .link_error_event_i(lev), .frame_lock_i(fl),
    .line_side_intl_flag_i(intl), .line_side_rev_code_i(rev), .sys_module_reset_i(srst),
    .call_progress_output_tx_level_o(txl), .call_progress_output_rx_level_o(rxl), .call_progress_output_tx_mute_o(txm), .call_progress_output_rx_mute_o(rxm),
    .call_progress_output_tx_atten_db_o(txa), .call_progress_output_rx_atten_db_o(rxa), .line_side_powerdown_o(lpd),
    .system_side_powerdown_o(spd), .sample_rate_select_o(rsel), .sample_rate_hz_o(rhz),
    .sample_rate_valid_o(rval), .legacy_rx_gain_o(lrxo), .legacy_tx_atten_o(ltxo), .loop_current_level_o(lvl));

  // model of loop current decode
  function automatic logic [3:0] loop_m(input logic o, input logic [4:0] c);
    if (o && c == 5'h1E) return 4'hE;
    if (o && c == 5'h01) return 4'h1;
    return c[4:1];
  endfunction : loop_m

  // model of each register read
  function automatic logic [7:0] exp_rd(input int i);
    case (i)
      6: return ctl | {4'h0, system_side_powerdown, 3'h0};
      9: return {5'h0, rate};
      11: return 8'h05;
      12: return {lerr, fl, 2'h0, loop_m(oh, code)};
      13: return {1'b0, intl, rev, lrx, ltx};
      default: return 8'h00;
    endcase
  endfunction : exp_rd

  task automatic close_out();
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  task automatic hang();
    num_errors++;
    hung = 1;
  endtask : hang

  // a spent wait ends the run
  always @(posedge sys_clk_i) if (hung) close_out();

  task automatic do_rst();
    @(posedge sys_clk_i) resetn_i <= 0;
    {ctl, system_side_powerdown, lerr, lrx, ltx, rate} = {8'h70, 7'h0};
    repeat (10) @(posedge sys_clk_i);
    resetn_i <= 1;
  endtask : do_rst

  // bus write, address and data offered together
  task automatic wm(input int i, input logic [7:0] v, input logic s);
    logic ah, wh, bh;
    logic [1:0] b;
    int n;
    @(posedge sys_clk_i);
    awv <= 1; wv <= 1; bre <= 1; awa <= 8'(i * 4); wd <= {24'($urandom), v};
    ws <= {3'($urandom), s}; prot <= 3'($urandom);
    bh = 0;
    for (n = 0; n < 40 && !bh; n++) begin
      @(negedge sys_clk_i);
      ah = awv && awr; wh = wv && wrd; bh = bv && bre; b = bresp;
      @(posedge sys_clk_i);
      if (ah) awv <= 0;
      if (wh) wv <= 0;
      if (bh) bre <= 0;
    end
    if (!bh) hang();
    `CHK(b, (i >= 6 && i <= 13) ? 2'h0 : 2'h2)
    if (s && i == 6) begin ctl = v & 8'h73; system_side_powerdown |= v[3]; end
    if (s && i == 9) rate = v[2:0];
    if (s && i == 12 && !v[7]) lerr = 0;
    if (s && i == 13) {lrx, ltx} = v[1:0];
  endtask : wm

  // bus read and compare with model
  task automatic rd(input int i);
    logic ah, rh;
    logic [31:0] q;
    logic [1:0] r;
    int n;
    @(posedge sys_clk_i);
    arv <= 1; rre <= 1; ara <= 8'(i * 4); prot <= 3'($urandom);
    rh = 0;
    for (n = 0; n < 40 && !rh; n++) begin
      @(negedge sys_clk_i);
      ah = arv && arr; rh = rv && rre; q = rdata; r = rresp;
      @(posedge sys_clk_i);
      if (ah) arv <= 0;
      if (rh) rre <= 0;
    end
    if (!rh) hang();
    `CHK(r, (i >= 6 && i <= 13) ? 2'h0 : 2'h2)
    `CHK(q, {24'h0, exp_rd(i)})
  endtask : rd

  // decoded outputs against model
  task automatic chk_out();
    logic [1:0] t, r;
    t = {ctl[6], ctl[1]};
    r = {ctl[5], ctl[0]};
    @(negedge sys_clk_i);
    `CHK({txl, rxl, txm, rxm}, {t, r, t == 2'h2, r == 2'h2})
    `CHK({txa, rxa}, {6'(txt[t]), 6'(rxt[r])})
    `CHK({lpd, spd, lrxo, ltxo}, {ctl[4], system_side_powerdown, lrx, ltx})
    `CHK({rsel, rhz, rval}, {rate, 14'(hzt[rate]), rate != 3'h7})
  endtask : chk_out

  task automatic scan();
    for (int i = 0; i < 16; i++) rd(i);
    rd(63);
  endtask : scan

  // main sequence
  initial begin
    k = $urandom(32'h226395B1);
    do_rst();
    scan();
    chk_out();
    for (k = 0; k < 8; k++) begin
      wm(9, 8'(k), 1);
      d = 8'($urandom);
      {d[6], d[1], d[5], d[0]} = {k[1:0], ~k[0], k[1]};
      wm(6, d, 1);
      chk_out();
    end
    for (k = 0; k < 40; k++) begin
      @(posedge sys_clk_i) {fl, intl, rev, oh, code} <= 12'($urandom);
      j = $urandom_range(15, 4);
      wm(j, 8'($urandom), 1'($urandom));
      rd(j);
      chk_out();
    end
    wm(6, 8'h08, 1);
    wm(6, 8'h00, 1);
    chk_out();
    @(posedge sys_clk_i) srst <= 1;
    @(posedge sys_clk_i) srst <= 0;
    system_side_powerdown = 0;
    chk_out();
    @(posedge sys_clk_i) lev <= 1;
    @(posedge sys_clk_i) lev <= 0;
    lerr = 1;
    rd(12);
    wm(12, 8'hFF, 1);
    rd(12);
    wm(12, 8'h00, 1);
    rd(12);
    // event beats a clear in the same cycle
    @(posedge sys_clk_i) lev <= 1;
    wm(12, 8'h00, 1);
    @(posedge sys_clk_i) lev <= 0;
    lerr = 1;
    rd(12);
    for (k = 0; k < 64; k++) begin
      @(posedge sys_clk_i) {oh, code} <= 6'(k);
      @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      `CHK(lvl, loop_m(oh, code))
    end
    do_rst();
    scan();
    chk_out();
    close_out();
  end
endmodule : daa_control_status_regs_tb

bind daacsr_top daacsr_chk u_daacsr_chk (.sys_clk_i, .resetn_i, .sys_module_reset_i, .off_hook_i,
  .line_volt_current_code_i, .s_axi_bvalid_o, .s_axi_rvalid_o, .s_axi_rdata_o, .call_progress_output_tx_level_o,
  .call_progress_output_rx_level_o, .call_progress_output_tx_mute_o, .call_progress_output_rx_mute_o, .call_progress_output_tx_atten_db_o, .call_progress_output_rx_atten_db_o,
  .line_side_powerdown_o, .system_side_powerdown_o, .sample_rate_select_o, .sample_rate_hz_o,
  .sample_rate_valid_o, .legacy_rx_gain_o, .legacy_tx_atten_o, .loop_current_level_o);
